// ==== core/adc_status_regs.vh ====
// Purpose: register addresses, bit positions and reset values of the converter status block
// Assumes: 8-bit special-function register bus, one byte per address
// Notes:   definitions only
`ifndef ADC_STATUS_REGS_VH
`define ADC_STATUS_REGS_VH

// register addresses
`define ADDR_STATUS      8'hd8
`define ADDR_MODE        8'hd1
`define ADDR_PRI_CTRL    8'hd2
`define ADDR_AUX_CTRL    8'hd3
`define ADDR_FILTER      8'hd4
`define ADDR_ICTRL       8'hd5
`define ADDR_PRI_RES     8'hd9
`define ADDR_AUX_RES     8'hdc
`define ADDR_PRI_OFF     8'he1
`define ADDR_PRI_GAIN    8'he4
`define ADDR_AUX_OFF     8'he9
`define ADDR_AUX_GAIN    8'heb

// status bit positions
`define ST_PRI_RDY       7
`define ST_AUX_RDY       6
`define ST_CAL           5
`define ST_NOREF         4
`define ST_PRI_ERR       3
`define ST_AUX_ERR       2

// mode register fields
`define MODE_PRI_EN      5
`define MODE_AUX_EN      4
`define MODE_FIELD_HI    2
`define MODE_FIELD_LO    0
`define MODE_POWERDOWN   3'h0
`define MODE_START_MIN   3'h2
`define MODE_WMASK       8'h37

// control register field: external reference selected
`define CTRL_EXTREF      6

// reset values
`define STATUS_RESET     8'h00
`define MODE_RESET       8'h00
`define CTRL_RESET       8'h00
`define FILTER_RESET     8'h80
`define ICTRL_RESET      8'h00
`define ZERO_BYTE        8'h00
`define PRI_RES_RESET    24'h000000
`define AUX_RES_RESET    16'h0000

// byte counts of the multi-byte banks
`define PRI_NBYTES       8'h03
`define AUX_NBYTES       8'h02

`endif

// ==== core/status_flag.v ====
// Purpose: one sticky status flag of the converter status register
// Assumes: set and clear are same-clock strobes
// Notes:   a set in the cycle of a clear wins
`timescale 1ns/1ps
`default_nettype none

module status_flag (
  input  wire clk,
  input  wire rst,
  input  wire set,
  input  wire clr,
  output reg  q
);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule // status_flag

`default_nettype wire

// ==== core/byte_bank.v ====
// Purpose: multi-byte result or coefficient register, loaded by hardware or byte-written by software
// Assumes: load and write are same-clock strobes; load wins over a write in the same cycle
// Notes:   byte 0 is the low byte
`timescale 1ns/1ps
`default_nettype none

module byte_bank #(
  parameter             NB        = 3,
  parameter [8*NB-1:0]  RESET_VAL = {NB{8'h00}}
) (
  input  wire            clk,
  input  wire            rst,
  input  wire            ld,
  input  wire [8*NB-1:0] ld_val,
  input  wire            wr,
  input  wire [1:0]      wr_idx,
  input  wire [7:0]      wr_byte,
  output wire [8*NB-1:0] value
);

  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_byte
      reg [7:0] byte_q;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          byte_q <= RESET_VAL[8*b +: 8];
        end else if (ld) begin
          byte_q <= ld_val[8*b +: 8];
        end else if (wr && ({30'd0, wr_idx} == b)) begin
          byte_q <= wr_byte;
        end
      end
      assign value[8*b +: 8] = byte_q;
    end
  endgenerate

endmodule // byte_bank

`default_nettype wire

// ==== core/adc_status_block.v ====
// Purpose: status, mode and result registers of a dual sigma-delta converter pair on the SFR bus
// Assumes: converter cores run on clk; reference fault pin is asynchronous
// Notes:   read data is registered one cycle after the address is presented
`timescale 1ns/1ps
`default_nettype none
`include "adc_status_regs.vh"

module adc_status_block #(
  parameter [23:0] PRI_OFF_RESET  = 24'h800000,
  parameter [23:0] PRI_GAIN_RESET = 24'h400000,
  parameter [15:0] AUX_OFF_RESET  = 16'h8000,
  parameter [15:0] AUX_GAIN_RESET = 16'h4000
) (
  input  wire        clk,
  input  wire        rst,
  // special-function register bus
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire [7:0]  sfr_wdata,
  input  wire        sfr_bit_wr,
  input  wire [2:0]  sfr_bit_idx,
  input  wire        sfr_bit_val,
  output reg  [7:0]  sfr_rdata_q,
  // primary converter core
  input  wire        pri_done,
  input  wire        pri_is_cal,
  input  wire        pri_cal_gain,
  input  wire        pri_cal_err,
  input  wire        pri_clamped,
  input  wire [23:0] pri_result,
  input  wire [23:0] pri_coeff_new,
  // auxiliary converter core
  input  wire        aux_done,
  input  wire        aux_is_cal,
  input  wire        aux_cal_gain,
  input  wire        aux_cal_err,
  input  wire        aux_clamped,
  input  wire [15:0] aux_result,
  input  wire [15:0] aux_coeff_new,
  // reference input pins below threshold or floating
  input  wire        ref_fault,
  // towards the converter cores
  output reg  [7:0]  mode_q,
  output reg         pri_start_q,
  output reg         aux_start_q,
  output reg  [7:0]  pri_ctrl_q,
  output reg  [7:0]  aux_ctrl_q,
  output reg  [7:0]  filter_config_q,
  output reg  [7:0]  ictrl_q,
  output reg  [7:0]  status_q
);

  // bus decode
  wire        wr_status = sfr_wr && (sfr_addr == `ADDR_STATUS);
  wire        wr_mode   = sfr_wr && (sfr_addr == `ADDR_MODE);
  wire        bit_wr    = sfr_bit_wr;

  wire [7:0]  po_rel    = sfr_addr - `ADDR_PRI_OFF;
  wire [7:0]  pg_rel    = sfr_addr - `ADDR_PRI_GAIN;
  wire [7:0]  ao_rel    = sfr_addr - `ADDR_AUX_OFF;
  wire [7:0]  ag_rel    = sfr_addr - `ADDR_AUX_GAIN;
  wire [7:0]  pr_rel    = sfr_addr - `ADDR_PRI_RES;
  wire [7:0]  ar_rel    = sfr_addr - `ADDR_AUX_RES;

  wire        hit_po    = (po_rel < `PRI_NBYTES);
  wire        hit_pg    = (pg_rel < `PRI_NBYTES);
  wire        hit_ao    = (ao_rel < `AUX_NBYTES);
  wire        hit_ag    = (ag_rel < `AUX_NBYTES);
  wire        hit_pr    = (pr_rel < `PRI_NBYTES);
  wire        hit_ar    = (ar_rel < `AUX_NBYTES);

  // a mode write with a mode code of 2 or above starts the enabled converters
  wire [2:0]  wr_field  = sfr_wdata[`MODE_FIELD_HI:`MODE_FIELD_LO];
  wire        start_any = wr_mode && (wr_field >= `MODE_START_MIN);
  wire        start_pri = start_any && sfr_wdata[`MODE_PRI_EN];
  wire        start_aux = start_any && sfr_wdata[`MODE_AUX_EN];

  // reference fault synchroniser
  reg         ref_meta_q;
  reg         ref_sync_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
    end else begin
      ref_meta_q <= ref_fault;
      ref_sync_q <= ref_meta_q;
    end
  end

  // converter activity from the mode register
  wire        mode_on    = (mode_q[`MODE_FIELD_HI:`MODE_FIELD_LO] != `MODE_POWERDOWN);
  wire        pri_active = mode_on && mode_q[`MODE_PRI_EN];
  wire        aux_active = mode_on && mode_q[`MODE_AUX_EN];
  wire        any_active = pri_active || aux_active;

  // flag storage
  wire        pri_rdy;
  wire        aux_rdy;
  wire        cal_flag;
  wire        pri_err;
  wire        aux_err;
  reg         noref_q;

  // completions are accepted only while the ready flag is clear
  wire        pri_acc   = pri_done && !pri_rdy;
  wire        aux_acc   = aux_done && !aux_rdy;

  wire        pri_force = noref_q && pri_ctrl_q[`CTRL_EXTREF];
  wire        aux_force = noref_q && aux_ctrl_q[`CTRL_EXTREF];

  wire [23:0] pri_store = pri_force ? {24{1'b1}} : pri_result;
  wire [15:0] aux_store = aux_force ? {16{1'b1}} : aux_result;

  wire        pri_res_ld  = pri_acc && !pri_is_cal;
  wire        aux_res_ld  = aux_acc && !aux_is_cal;
  wire        pri_coef_ok = pri_acc && pri_is_cal && !pri_cal_err;
  wire        aux_coef_ok = aux_acc && aux_is_cal && !aux_cal_err;

  wire        pri_err_set = (pri_res_ld && (pri_clamped || pri_force)) ||
                            (pri_acc && pri_is_cal && pri_cal_err);
  wire        aux_err_set = (aux_res_ld && (aux_clamped || aux_force)) ||
                            (aux_acc && aux_is_cal && aux_cal_err);

  // software clears of the ready flags, by byte or bit write of zero
  wire        pri_sw_clr = (wr_status && !sfr_wdata[`ST_PRI_RDY]) ||
                           (bit_wr && (sfr_bit_idx == `ST_PRI_RDY) && !sfr_bit_val);
  wire        aux_sw_clr = (wr_status && !sfr_wdata[`ST_AUX_RDY]) ||
                           (bit_wr && (sfr_bit_idx == `ST_AUX_RDY) && !sfr_bit_val);

  status_flag u_pri_rdy (
    .clk (clk),
    .rst (rst),
    .set (pri_acc),
    .clr (pri_sw_clr || start_pri),
    .q   (pri_rdy)
  );

  status_flag u_aux_rdy (
    .clk (clk),
    .rst (rst),
    .set (aux_acc),
    .clr (aux_sw_clr || start_aux),
    .q   (aux_rdy)
  );

  status_flag u_cal (
    .clk (clk),
    .rst (rst),
    .set ((pri_acc && pri_is_cal) || (aux_acc && aux_is_cal)),
    .clr (start_any),
    .q   (cal_flag)
  );

  status_flag u_pri_err (
    .clk (clk),
    .rst (rst),
    .set (pri_err_set),
    .clr (start_pri),
    .q   (pri_err)
  );

  status_flag u_aux_err (
    .clk (clk),
    .rst (rst),
    .set (aux_err_set),
    .clr (start_aux),
    .q   (aux_err)
  );

  // missing reference tracks the pin only while a converter runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      noref_q <= 1'b0;
    end else begin
      noref_q <= any_active && ref_sync_q;
    end
  end

  // result and coefficient banks
  wire [23:0] pri_res_val;
  wire [15:0] aux_res_val;
  wire [23:0] pri_off_val;
  wire [23:0] pri_gain_val;
  wire [15:0] aux_off_val;
  wire [15:0] aux_gain_val;

  byte_bank #(.NB(3), .RESET_VAL(`PRI_RES_RESET)) u_pri_res (
    .clk     (clk),
    .rst     (rst),
    .ld      (pri_res_ld),
    .ld_val  (pri_store),
    .wr      (1'b0),
    .wr_idx  (2'b00),
    .wr_byte (`ZERO_BYTE),
    .value   (pri_res_val)
  );

  byte_bank #(.NB(2), .RESET_VAL(`AUX_RES_RESET)) u_aux_res (
    .clk     (clk),
    .rst     (rst),
    .ld      (aux_res_ld),
    .ld_val  (aux_store),
    .wr      (1'b0),
    .wr_idx  (2'b00),
    .wr_byte (`ZERO_BYTE),
    .value   (aux_res_val)
  );

  byte_bank #(.NB(3), .RESET_VAL(PRI_OFF_RESET)) u_pri_off (
    .clk     (clk),
    .rst     (rst),
    .ld      (pri_coef_ok && !pri_cal_gain),
    .ld_val  (pri_coeff_new),
    .wr      (sfr_wr && hit_po),
    .wr_idx  (po_rel[1:0]),
    .wr_byte (sfr_wdata),
    .value   (pri_off_val)
  );

  byte_bank #(.NB(3), .RESET_VAL(PRI_GAIN_RESET)) u_pri_gain (
    .clk     (clk),
    .rst     (rst),
    .ld      (pri_coef_ok && pri_cal_gain),
    .ld_val  (pri_coeff_new),
    .wr      (sfr_wr && hit_pg),
    .wr_idx  (pg_rel[1:0]),
    .wr_byte (sfr_wdata),
    .value   (pri_gain_val)
  );

  byte_bank #(.NB(2), .RESET_VAL(AUX_OFF_RESET)) u_aux_off (
    .clk     (clk),
    .rst     (rst),
    .ld      (aux_coef_ok && !aux_cal_gain),
    .ld_val  (aux_coeff_new),
    .wr      (sfr_wr && hit_ao),
    .wr_idx  (ao_rel[1:0]),
    .wr_byte (sfr_wdata),
    .value   (aux_off_val)
  );

  byte_bank #(.NB(2), .RESET_VAL(AUX_GAIN_RESET)) u_aux_gain (
    .clk     (clk),
    .rst     (rst),
    .ld      (aux_coef_ok && aux_cal_gain),
    .ld_val  (aux_coeff_new),
    .wr      (sfr_wr && hit_ag),
    .wr_idx  (ag_rel[1:0]),
    .wr_byte (sfr_wdata),
    .value   (aux_gain_val)
  );

  // status image; reserved bits read zero
  wire [7:0]  status_d = {pri_rdy, aux_rdy, cal_flag, noref_q, pri_err, aux_err, 2'b00};

  // plain software registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q          <= `MODE_RESET;
      pri_ctrl_q      <= `CTRL_RESET;
      aux_ctrl_q      <= `CTRL_RESET;
      filter_config_q <= `FILTER_RESET;
      ictrl_q         <= `ICTRL_RESET;
      pri_start_q     <= 1'b0;
      aux_start_q     <= 1'b0;
      status_q        <= `STATUS_RESET;
    end else begin
      if (wr_mode) begin
        mode_q <= sfr_wdata & `MODE_WMASK;
      end
      if (sfr_wr && (sfr_addr == `ADDR_PRI_CTRL)) begin
        pri_ctrl_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == `ADDR_AUX_CTRL)) begin
        aux_ctrl_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == `ADDR_FILTER)) begin
        filter_config_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == `ADDR_ICTRL)) begin
        ictrl_q <= sfr_wdata;
      end
      pri_start_q <= start_pri;
      aux_start_q <= start_aux;
      status_q    <= status_d;
    end
  end

  // registered read mux; unmapped addresses read zero
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = `ZERO_BYTE;
    if (sfr_addr == `ADDR_STATUS) begin
      rdata_d = status_d;
    end else if (sfr_addr == `ADDR_MODE) begin
      rdata_d = mode_q;
    end else if (sfr_addr == `ADDR_PRI_CTRL) begin
      rdata_d = pri_ctrl_q;
    end else if (sfr_addr == `ADDR_AUX_CTRL) begin
      rdata_d = aux_ctrl_q;
    end else if (sfr_addr == `ADDR_FILTER) begin
      rdata_d = filter_config_q;
    end else if (sfr_addr == `ADDR_ICTRL) begin
      rdata_d = ictrl_q;
    end else if (hit_pr) begin
      rdata_d = pri_res_val[{pr_rel[1:0], 3'b000} +: 8];
    end else if (hit_ar) begin
      rdata_d = aux_res_val[{ar_rel[0], 3'b000} +: 8];
    end else if (hit_po) begin
      rdata_d = pri_off_val[{po_rel[1:0], 3'b000} +: 8];
    end else if (hit_pg) begin
      rdata_d = pri_gain_val[{pg_rel[1:0], 3'b000} +: 8];
    end else if (hit_ao) begin
      rdata_d = aux_off_val[{ao_rel[0], 3'b000} +: 8];
    end else if (hit_ag) begin
      rdata_d = aux_gain_val[{ag_rel[0], 3'b000} +: 8];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_q <= `ZERO_BYTE;
    end else begin
      sfr_rdata_q <= rdata_d;
    end
  end

endmodule // adc_status_block

`default_nettype wire

// ==== sim/adc_status_asserts.sv ====
// Purpose: port-level checks of the converter status block
// Assumes: one clock, async active-high reset
// Notes:   bound to the status block below
`timescale 1ns/1ps
`default_nettype none

module adc_status_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       pri_done,
  input wire logic       pri_is_cal,
  input wire logic       pri_clamped,
  input wire logic       aux_done,
  input wire logic       aux_is_cal,
  input wire logic       aux_clamped,
  input wire logic [7:0] mode_q,
  input wire logic       pri_start_q,
  input wire logic       aux_start_q,
  input wire logic [7:0] status_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pri_go;
    sfr_wr && sfr_addr == 8'hd1 && sfr_wdata[5] && sfr_wdata[2:0] >= 3'h2;
  endsequence
  sequence aux_go;
    sfr_wr && sfr_addr == 8'hd1 && sfr_wdata[4] && sfr_wdata[2:0] >= 3'h2;
  endsequence
  sequence no_done;
    !pri_done && !aux_done;
  endsequence

  // status_q lags the flags by one cycle, so the ready state seen by a completion shows one edge later
  a_pri_rdy_set: assert property (pri_done ##1 !status_q[7] |-> ##1 status_q[7])
    else $error("primary ready not set");
  a_aux_rdy_set: assert property (aux_done ##1 !status_q[6] |-> ##1 status_q[6])
    else $error("auxiliary ready not set");
  a_start_clears: assert property ((pri_go and no_done) ##1 no_done |-> ##1 (status_q & 8'ha8) == 8'h00)
    else $error("start write left flags set");
  a_start_pulse: assert property (pri_go ##1 !sfr_wr |-> pri_start_q ##1 !pri_start_q)
    else $error("start pulse wrong");
  a_aux_start_pulse: assert property (aux_go ##1 !sfr_wr |-> aux_start_q ##1 !aux_start_q)
    else $error("auxiliary start pulse wrong");
  a_mode_write: assert property (sfr_wr && sfr_addr == 8'hd1 |=> mode_q == ($past(sfr_wdata) & 8'h37))
    else $error("mode register wrong");
  a_noref_idle: assert property ((mode_q[2:0] == 3'h0) [*4] |-> !status_q[4])
    else $error("missing reference while idle");
  a_pri_clamp: assert property ((pri_done && !pri_is_cal && pri_clamped) ##1 !status_q[7] |-> ##1 status_q[3])
    else $error("primary error not set");
  a_aux_clamp: assert property ((aux_done && !aux_is_cal && aux_clamped) ##1 !status_q[6] |-> ##1 status_q[2])
    else $error("auxiliary error not set");
endmodule // adc_status_checker

bind adc_status_block adc_status_checker u_adc_status_checker (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
  .pri_done, .pri_is_cal, .pri_clamped, .aux_done, .aux_is_cal, .aux_clamped, .mode_q, .pri_start_q,
  .aux_start_q, .status_q);

`default_nettype wire

// ==== sim/conv_model.sv ====
// Purpose: behavioural converter cores and reference pin
// Assumes: completions driven just after a rising edge
// Notes:   both cores share qualifier and data lines
`timescale 1ns/1ps
`default_nettype none

module conv_model (
  input  wire logic        clk,
  output var  logic        pri_done,
  output var  logic        aux_done,
  output var  logic        is_cal,
  output var  logic        cal_gain,
  output var  logic        cal_err,
  output var  logic        clamped,
  output var  logic [23:0] data,
  output var  logic        ref_fault
);
  initial begin
    {pri_done, aux_done, is_cal, cal_gain, cal_err, clamped, ref_fault} = 7'h00;
    data = 24'h000000;
  end

  // one completion pulse; data shows the inverse once released
  task finish(input a, input c, input g, input e, input k, input [23:0] v);
    @(posedge clk);
    #1 {pri_done, aux_done, is_cal, cal_gain, cal_err, clamped} = {!a, a, c, g, e, k};
    data = v;
    @(posedge clk);
    #1 {pri_done, aux_done, is_cal, cal_gain, cal_err, clamped} = 6'h00;
    data = ~v;
  endtask

  task set_ref(input v);
    @(posedge clk);
    #1 ref_fault = v;
  endtask
endmodule // conv_model

`default_nettype wire

// ==== sim/dual_adc_status_and_results_test.sv ====
// Purpose: self-checking bench of the converter status block
// Assumes: register reads answer one edge after the address
// Notes:   converter cores come from conv_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module dual_adc_status_and_results_test;
  logic        clk, rst, sfr_wr, sfr_bit_wr, sfr_bit_val;
  logic [7:0]  sfr_addr, sfr_wdata;
  logic [2:0]  sfr_bit_idx;
  wire  [7:0]  sfr_rdata_q;
  wire         pri_done, aux_done, is_cal, cal_gain, cal_err, clamped, ref_fault;
  wire  [23:0] data;
  int          err_count = 0;
  int          num_checks = 0;

  conv_model u_model (.clk(clk), .pri_done(pri_done), .aux_done(aux_done), .is_cal(is_cal),
    .cal_gain(cal_gain), .cal_err(cal_err), .clamped(clamped), .data(data), .ref_fault(ref_fault));

  adc_status_block u_adc_status_block (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val),
    .sfr_rdata_q(sfr_rdata_q), .pri_done(pri_done), .pri_is_cal(is_cal), .pri_cal_gain(cal_gain),
    .pri_cal_err(cal_err), .pri_clamped(clamped), .pri_result(data), .pri_coeff_new(data),
    .aux_done(aux_done), .aux_is_cal(is_cal), .aux_cal_gain(cal_gain), .aux_cal_err(cal_err),
    .aux_clamped(clamped), .aux_result(data[15:0]), .aux_coeff_new(data[15:0]), .ref_fault(ref_fault),
    .mode_q(), .pri_start_q(), .aux_start_q(), .pri_ctrl_q(), .aux_ctrl_q(), .filter_config_q(),
    .ictrl_q(), .status_q());

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask

  task bwr(input [2:0] i, input v);
    @(posedge clk);
    #1 {sfr_bit_wr, sfr_bit_idx, sfr_bit_val} = {1'b1, i, v};
    @(posedge clk);
    #1 sfr_bit_wr = 1'b0;
  endtask

  task rdm(input [7:0] a, input [7:0] m, input [7:0] e);
    @(posedge clk);
    #1 sfr_addr = a;
    @(posedge clk);
    #1 `CHK(sfr_rdata_q & m, e)
  endtask

  task rd(input [7:0] a, input [7:0] e);
    rdm(a, 8'hff, e);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #20000;
    err_count++;
    end_of_test;
  end

  initial begin
    {rst, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_bit_idx, sfr_addr, sfr_wdata} = {4'h8, 3'h0, 8'h00, 8'h00};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd(8'hd8, 8'h00);
    rd(8'hd1, 8'h00);
    rd(8'hd4, 8'h80);
    rd(8'he3, 8'h80);
    rd(8'he6, 8'h40);
    rd(8'hea, 8'h80);
    rd(8'hec, 8'h40);
    rd(8'hc0, 8'h00);
    wr(8'hd4, 8'h03);
    rd(8'hd4, 8'h03);
    wr(8'hd5, 8'h5a);
    rd(8'hd5, 8'h5a);
    $display("reset test done");
    wr(8'hd1, 8'h22);
    rd(8'hd1, 8'h22);
    u_model.finish(0, 0, 0, 0, 0, 24'h123456);
    rd(8'hd8, 8'h80);
    rd(8'hd9, 8'h56);
    rd(8'hda, 8'h34);
    rd(8'hdb, 8'h12);
    u_model.finish(0, 0, 0, 0, 0, 24'h654321);
    wr(8'hd9, 8'haa);
    rd(8'hd9, 8'h56);
    bwr(3'h7, 1'b1);
    rd(8'hd8, 8'h80);
    bwr(3'h7, 1'b0);
    rd(8'hd8, 8'h00);
    u_model.finish(0, 0, 0, 0, 1, 24'hffffff);
    rd(8'hd8, 8'h88);
    wr(8'hd8, 8'h7f);
    rd(8'hd8, 8'h08);
    wr(8'hd1, 8'h22);
    rd(8'hd8, 8'h00);
    $display("primary test done");
    wr(8'hd1, 8'h12);
    u_model.finish(1, 0, 0, 0, 1, 24'h00ffff);
    rd(8'hd8, 8'h44);
    u_model.finish(1, 0, 0, 0, 0, 24'h001234);
    rd(8'hdc, 8'hff);
    rd(8'hdd, 8'hff);
    wr(8'hd1, 8'h12);
    rd(8'hd8, 8'h00);
    $display("auxiliary test done");
    wr(8'hd1, 8'h24);
    u_model.finish(0, 1, 0, 0, 0, 24'h0a0b0c);
    rd(8'hd8, 8'ha0);
    rd(8'he1, 8'h0c);
    rd(8'he3, 8'h0a);
    bwr(3'h7, 1'b0);
    rd(8'hd8, 8'h20);
    u_model.finish(0, 1, 1, 1, 0, 24'h777777);
    rdm(8'hd8, 8'h88, 8'h88);
    rd(8'he6, 8'h40);
    u_model.finish(1, 1, 1, 0, 0, 24'h001357);
    rd(8'heb, 8'h57);
    rd(8'hec, 8'h13);
    wr(8'hd1, 8'h32);
    rd(8'hd8, 8'h00);
    $display("calibration test done");
    wr(8'hd2, 8'h40);
    rd(8'hd2, 8'h40);
    u_model.set_ref(1'b1);
    repeat (4) @(posedge clk);
    rd(8'hd8, 8'h10);
    u_model.finish(0, 0, 0, 0, 0, 24'h000123);
    rd(8'hd8, 8'h98);
    rd(8'hd9, 8'hff);
    rd(8'hdb, 8'hff);
    u_model.set_ref(1'b0);
    repeat (4) @(posedge clk);
    rd(8'hd8, 8'h88);
    bwr(3'h7, 1'b0);
    fork
      u_model.finish(0, 0, 0, 0, 0, 24'h000010);
      bwr(3'h7, 1'b0);
    join
    rdm(8'hd8, 8'h80, 8'h80);
    wr(8'hd1, 8'h00);
    u_model.set_ref(1'b1);
    repeat (4) @(posedge clk);
    rdm(8'hd8, 8'h10, 8'h00);
    $display("reference test done");
    end_of_test;
  end
endmodule // dual_adc_status_and_results_test

`default_nettype wire
